//--- design/stx_pkg.sv
package stx_pkg;

	// Four clock phases of one instruction cycle
	typedef enum logic [1:0] {
		STX_Q1,
		STX_Q2,
		STX_Q3,
		STX_Q4
	} stx_phase_type;

	// Cycle kinds of the sequencer
	typedef enum logic [1:0] {
		STX_EXEC,
		STX_NOP1,
		STX_NOP2
	} stx_state_type;

	// Opcode field positions
	localparam int STX_OPC7_LSB  = 9;  // File test skip opcode field, bits 15:9
	localparam int STX_OPC8_LSB  = 8;  // Literal opcode field, bits 15:8
	localparam int STX_BANK_BIT  = 8;  // Bank operand position
	localparam int STX_OPND_MSB  = 7;  // Top bit of the 8-bit operand
	localparam int STX_SIGN_BIT  = 7;  // Sign bit of an 8-bit result

	// Opcode values
	localparam logic [6:0] STX_OPC_TEST_SKIP = 7'h33;  // 0110 011
	localparam logic [7:0] STX_OPC_XOR_LIT   = 8'h0A;  // 0000 1010

	// Highest file address handled as indexed literal offset
	localparam logic [7:0] STX_INDEXED_LIMIT = 8'h5F;

	// Reset values
	localparam logic [7:0]  STX_ACC_RESET   = 8'h00;
	localparam logic [15:0] STX_WORD_RESET  = 16'h0000;
	localparam logic [7:0]  STX_BYTE_ZERO   = 8'h00;
	localparam logic [3:0]  STX_BANK_RESET  = 4'h0;

endpackage

//--- design/stx_exec.sv
`timescale 1ns/100ps

// Notes on behaviour
// - Zero file register skips next word, two cycles
// - Skipped two-word instruction costs three cycles total
// - Bank operand picks shared bank or selector bank
// - Shared bank, extension on, low address: indexed
// - Literal XOR with accumulator forms the result
// - XOR result written in fourth phase, flags updated
module stx_exec (
	input  wire logic                   clock,
	input  wire logic                   resetn,
	input  wire logic                   instr_valid,
	input  wire logic [15:0]            instr_word,
	input  wire logic                   next_is_two_word,
	input  wire logic                   extended_enable,
	input  wire logic [3:0]             bank_selector,
	input  wire logic [7:0]             file_rd_data,
	output logic                        instr_accept,
	output logic                        file_rd_strobe,
	output logic [7:0]                  file_addr,
	output logic [3:0]                  file_bank,
	output logic                        shared_bank_sel,
	output logic                        indexed_mode,
	output logic                        fetch_discard,
	output logic [7:0]                  accumulator,
	output logic                        negative_flag,
	output logic                        zero_flag,
	output stx_pkg::stx_phase_type      phase
);

	// Sequencer state
	stx_pkg::stx_phase_type phase_q;    // Current clock phase
	stx_pkg::stx_phase_type phase_d;    // Next clock phase
	stx_pkg::stx_state_type state_q;    // Current cycle kind
	stx_pkg::stx_state_type state_d;    // Next cycle kind

	// Instruction being executed
	logic [15:0] instr_q;               // Latched instruction word
	logic        live_q;                // Latched word is in execution
	logic        two_q;                 // Skipped word was two words long

	// Data path
	logic [7:0]  opnd_q;                // Operand read in second phase
	logic [7:0]  result_q;              // Result formed in third phase
	logic        test_zero_q;           // Tested register read as zero
	logic [7:0]  acc_q;                 // Accumulator
	logic        neg_q;                 // Negative flag
	logic        zero_q;                // Zero flag

	// File address outputs, held from flops
	logic [7:0]  faddr_q;               // File address
	logic [3:0]  fbank_q;               // Bank from selector
	logic        shared_q;              // Shared bank selected
	logic        indexed_q;             // Indexed literal offset mode

	// Decode of the latched word
	wire         is_test_skip;          // Test file, skip if zero
	wire         is_xor_lit;            // XOR literal into accumulator
	wire [7:0]   opnd_field;            // Low 8 bits of the word
	wire         bank_bit;              // Bank operand

	// Decode of the incoming word for address setup
	wire         in_bank_bit;           // Bank operand of new word
	wire [7:0]   in_opnd;               // File address of new word
	wire         in_indexed;            // New word uses indexed mode

	// Phase and sequencer decodes
	wire         at_q1;
	wire         at_q2;
	wire         at_q3;
	wire         at_q4;
	wire         exec_cycle;            // Not a discarded cycle
	wire         take_word;             // New word taken this edge
	wire [7:0]   xor_value;             // Combinational XOR result
	wire         skip_now;              // Skip decided at end of cycle

	assign is_test_skip = live_q &&
		(instr_q[15:stx_pkg::STX_OPC7_LSB] == stx_pkg::STX_OPC_TEST_SKIP);
	assign is_xor_lit   = live_q &&
		(instr_q[15:stx_pkg::STX_OPC8_LSB] == stx_pkg::STX_OPC_XOR_LIT);
	assign opnd_field   = instr_q[stx_pkg::STX_OPND_MSB:0];
	assign bank_bit     = instr_q[stx_pkg::STX_BANK_BIT];

	assign in_bank_bit  = instr_word[stx_pkg::STX_BANK_BIT];
	assign in_opnd      = instr_word[stx_pkg::STX_OPND_MSB:0];
	// Shared bank, extension on and low address gives indexed mode
	assign in_indexed   = !in_bank_bit && extended_enable &&
		(in_opnd <= stx_pkg::STX_INDEXED_LIMIT);

	assign at_q1 = (phase_q == stx_pkg::STX_Q1);
	assign at_q2 = (phase_q == stx_pkg::STX_Q2);
	assign at_q3 = (phase_q == stx_pkg::STX_Q3);
	assign at_q4 = (phase_q == stx_pkg::STX_Q4);

	assign exec_cycle = (state_q == stx_pkg::STX_EXEC);
	assign take_word  = at_q1 && exec_cycle && instr_valid;

	// XOR of accumulator and literal
	assign xor_value = acc_q ^ opnd_field;

	// Zero register read ends the cycle with a skip
	assign skip_now = at_q4 && is_test_skip && test_zero_q;

	// Phase advance, wraps every four clocks
	always_comb begin
		case (phase_q)
			stx_pkg::STX_Q1: phase_d = stx_pkg::STX_Q2;
			stx_pkg::STX_Q2: phase_d = stx_pkg::STX_Q3;
			stx_pkg::STX_Q3: phase_d = stx_pkg::STX_Q4;
			stx_pkg::STX_Q4: phase_d = stx_pkg::STX_Q1;
			default:         phase_d = stx_pkg::STX_Q1;
		endcase
	end

	// Cycle kind changes only at the fourth phase
	always_comb begin
		state_d = state_q;
		case (state_q)
			stx_pkg::STX_EXEC: begin
				// Skip discards the prefetched word
				if (skip_now) begin
					state_d = stx_pkg::STX_NOP1;
				end
			end
			stx_pkg::STX_NOP1: begin
				// Second word of a skipped instruction also discarded
				if (at_q4) begin
					state_d = two_q ? stx_pkg::STX_NOP2
						: stx_pkg::STX_EXEC;
				end
			end
			stx_pkg::STX_NOP2: begin
				if (at_q4) begin
					state_d = stx_pkg::STX_EXEC;
				end
			end
			default: begin
				state_d = stx_pkg::STX_EXEC;
			end
		endcase
	end

	// Phase and cycle kind registers
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			phase_q <= stx_pkg::STX_Q1;
			state_q <= stx_pkg::STX_EXEC;
		end else begin
			phase_q <= phase_d;
			state_q <= state_d;
		end
	end

	// Word latch at the first phase; released at the fourth
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			instr_q <= stx_pkg::STX_WORD_RESET;
			live_q  <= 1'b0;
		end else if (take_word) begin
			instr_q <= instr_word;
			live_q  <= 1'b1;
		end else if (at_q4) begin
			live_q  <= 1'b0;
		end
	end

	// Length of the skipped word, caught when the skip is decided
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			two_q <= 1'b0;
		end else if (skip_now) begin
			two_q <= next_is_two_word;
		end
	end

	// File address setup with the new word
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			faddr_q   <= stx_pkg::STX_BYTE_ZERO;
			fbank_q   <= stx_pkg::STX_BANK_RESET;
			shared_q  <= 1'b0;
			indexed_q <= 1'b0;
		end else if (take_word) begin
			faddr_q   <= in_opnd;
			fbank_q   <= bank_selector;
			shared_q  <= !in_bank_bit;
			indexed_q <= in_indexed;
		end
	end

	// Operand read in the second phase, processed in the third
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			opnd_q      <= stx_pkg::STX_BYTE_ZERO;
			result_q    <= stx_pkg::STX_BYTE_ZERO;
			test_zero_q <= 1'b0;
		end else begin
			if (at_q2 && is_test_skip) begin
				opnd_q <= file_rd_data;
			end
			if (at_q3 && is_test_skip) begin
				test_zero_q <= (opnd_q == stx_pkg::STX_BYTE_ZERO);
			end
			if (at_q3 && is_xor_lit) begin
				result_q <= xor_value;
			end
		end
	end

	// Accumulator and flags written in the fourth phase
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			acc_q  <= stx_pkg::STX_ACC_RESET;
			neg_q  <= 1'b0;
			zero_q <= 1'b0;
		end else if (at_q4 && is_xor_lit) begin
			acc_q  <= result_q;
			neg_q  <= result_q[stx_pkg::STX_SIGN_BIT];
			zero_q <= (result_q == stx_pkg::STX_BYTE_ZERO);
		end
	end

	// Handshake outputs; discarded cycles take no word
	assign instr_accept   = at_q1 && exec_cycle;
	assign file_rd_strobe = at_q2 && is_test_skip;
	assign fetch_discard  = !exec_cycle;

	// Data outputs from flops
	assign file_addr       = faddr_q;
	assign file_bank       = fbank_q;
	assign shared_bank_sel = shared_q;
	assign indexed_mode    = indexed_q;
	assign accumulator     = acc_q;
	assign negative_flag   = neg_q;
	assign zero_flag       = zero_q;
	assign phase           = phase_q;

endmodule

//--- sim/stx_exec_checker.sv
`timescale 1ns/100ps
// Port watcher for the execution block
module stx_exec_checker (
	input wire logic                   clock,
	input wire logic                   resetn,
	input wire logic                   instr_valid,
	input wire logic [15:0]            instr_word,
	input wire logic                   next_is_two_word,
	input wire logic                   extended_enable,
	input wire logic [3:0]             bank_selector,
	input wire logic [7:0]             file_rd_data,
	input wire logic                   instr_accept,
	input wire logic                   file_rd_strobe,
	input wire logic [7:0]             file_addr,
	input wire logic [3:0]             file_bank,
	input wire logic                   shared_bank_sel,
	input wire logic                   indexed_mode,
	input wire logic                   fetch_discard,
	input wire logic [7:0]             accumulator,
	input wire logic                   negative_flag,
	input wire logic                   zero_flag,
	input wire stx_pkg::stx_phase_type phase
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// Word taken at this edge
	wire take = phase == stx_pkg::STX_Q1 && instr_accept && instr_valid;
	wire is_xor = take && instr_word[15:8] == stx_pkg::STX_OPC_XOR_LIT;
	// Zero operand read, then the Q4 edge
	sequence zero_read_s;
		file_rd_strobe && file_rd_data == 8'h00 ##2 1'b1;
	endsequence
	property bank_p;
		logic [15:0] w;
		logic [3:0] s;
		(take, w = instr_word, s = bank_selector) |=> shared_bank_sel == !w[8]
			&& file_bank == s && file_addr == w[7:0];
	endproperty
	property idx_p;
		logic x;
		(take, x = !instr_word[8] && extended_enable
			&& instr_word[7:0] <= 8'h5F) |=> indexed_mode == x;
	endproperty
	property xv_p;
		logic [7:0] r;
		(is_xor, r = accumulator ^ instr_word[7:0]) |-> ##4 accumulator == r;
	endproperty
	skip_one_a: assert property (zero_read_s ##0 !next_is_two_word
		|=> fetch_discard [*4] ##1 !fetch_discard) else $error("skip length");
	skip_two_a: assert property (zero_read_s ##0 next_is_two_word
		|=> fetch_discard [*8] ##1 !fetch_discard) else $error("long skip");
	no_skip_a: assert property (file_rd_strobe && file_rd_data != 8'h00
		|-> ##3 !fetch_discard && instr_accept) else $error("false skip");
	test_flags_a: assert property (file_rd_strobe |-> ##1
		$stable({accumulator, negative_flag, zero_flag}) [*3])
		else $error("test changed state");
	bank_pick_a: assert property (bank_p) else $error("bank pick");
	indexed_mode_a: assert property (idx_p) else $error("indexed");
	xor_value_a: assert property (xv_p) else $error("xor value");
	xor_phase_a: assert property (is_xor |=> $stable(accumulator) [*3])
		else $error("early write");
	xor_flags_a: assert property (is_xor |-> ##4
		negative_flag == accumulator[7] && zero_flag == (accumulator == 8'h00))
		else $error("xor flags");
endmodule

//--- sim/stx_exec_bench.sv
`timescale 1ns/100ps
// Bench top for the execution block
module stx_exec_bench;
	logic                   clock = 0, resetn = 0, instr_valid = 0;
	logic                   next_is_two_word = 0, extended_enable = 0;
	logic [15:0]            instr_word = 16'h0000;
	logic [3:0]             bank_selector = 4'h0, file_bank;
	logic [7:0]             file_rd_data = 8'h00, file_addr, accumulator;
	logic                   instr_accept, file_rd_strobe, shared_bank_sel;
	logic                   indexed_mode, fetch_discard, negative_flag, zero_flag;
	stx_pkg::stx_phase_type phase;
	int                     n_mismatch = 0, samples_checked = 0;
	// Free running clock
	always #2 clock = ~clock;
	stx_exec stx_exec_inst (.clock, .resetn, .instr_valid, .instr_word,
		.next_is_two_word, .extended_enable, .bank_selector, .file_rd_data,
		.instr_accept, .file_rd_strobe, .file_addr, .file_bank, .shared_bank_sel,
		.indexed_mode, .fetch_discard, .accumulator, .negative_flag, .zero_flag,
		.phase);
	// One comparison
	task automatic chk(input string nm, input logic [15:0] e, s);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Counts and verdict
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Offer one word until a Q1 with accept high takes it
	task automatic issue(input logic [15:0] w);
		int i;
		for (i = 0; i < 20 && !(phase == stx_pkg::STX_Q1 && instr_accept); i++)
			@(negedge clock);
		instr_word = w;
		instr_valid = 1;
		@(posedge clock);
		@(negedge clock);
		instr_valid = 0;
	endtask
	// Literal XOR, result must wait for the Q4 edge
	task automatic t_xor(input logic [7:0] k, e);
		issue({stx_pkg::STX_OPC_XOR_LIT, k});
		repeat (2) @(negedge clock);
		chk("phase", 16'(stx_pkg::STX_Q4), 16'(phase));
		chk("acc before q4", e ^ k, accumulator);
		@(negedge clock);
		chk("accumulator", e, accumulator);
		chk("negative_flag", e[7], negative_flag);
		chk("zero_flag", e == 8'h00, zero_flag);
		$display("test xor %h done", k);
	endtask
	// File test, bank outputs and count of discarded cycles
	task automatic t_skip(input logic [15:0] w, input logic [7:0] d,
		input logic two, x, input int n);
		int i, c;
		logic [7:0] a;
		logic       n0, z0;
		a = accumulator;
		n0 = negative_flag;
		z0 = zero_flag;
		file_rd_data = d;
		next_is_two_word = two;
		extended_enable = x;
		bank_selector = w[7:4];
		issue(w);
		chk("file_rd_strobe", 1'b1, file_rd_strobe);
		chk("file_addr", w[7:0], file_addr);
		chk("shared_bank_sel", !w[8], shared_bank_sel);
		chk("file_bank", w[7:4], file_bank);
		chk("indexed_mode", !w[8] && x && w[7:0] <= 8'h5F, indexed_mode);
		c = 0;
		for (i = 0; i < 16; i++) begin
			@(negedge clock);
			c += (fetch_discard === 1'b1);
		end
		chk("discard cycles", 16'(n), 16'(c));
		chk("accumulator", a, accumulator);
		chk("negative_flag", n0, negative_flag);
		chk("zero_flag", z0, zero_flag);
		$display("test skip %h done", w);
	endtask
	// Main sequence
	initial begin
		repeat (4) @(posedge clock);
		@(negedge clock);
		resetn = 1;
		t_xor(8'hB5, 8'hB5);
		t_xor(8'hAF, 8'h1A);
		t_xor(8'h1A, 8'h00);
		t_skip(16'h6650, 8'h00, 1'b0, 1'b1, 4);
		t_skip(16'h6760, 8'h00, 1'b1, 1'b1, 8);
		t_skip(16'h665F, 8'h01, 1'b1, 1'b1, 0);
		t_skip(16'h6660, 8'h00, 1'b0, 1'b1, 4);
		t_skip(16'h6630, 8'h00, 1'b0, 1'b0, 4);
		conclude();
	end
	// Hang guard
	initial begin
		#4000;
		n_mismatch++;
		conclude();
	end
endmodule
bind stx_exec stx_exec_checker stx_exec_checker_inst (.clock, .resetn,
	.instr_valid, .instr_word, .next_is_two_word, .extended_enable,
	.bank_selector, .file_rd_data, .instr_accept, .file_rd_strobe, .file_addr,
	.file_bank, .shared_bank_sel, .indexed_mode, .fetch_discard, .accumulator,
	.negative_flag, .zero_flag, .phase);
